// ### bench/bsq_burner_model.sv
// Burner model: pilot flame that lights a while after the pilot valve opens
`timescale 1ns/1ps
module bsq_burner_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire bsq_pkg::bsq_outs_t outs,
  input wire logic light,
  output logic flame
);
  import bsq_pkg::*;
  int n;
  // Flame only while gas flows and ignition is allowed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      n <= 0;
      flame <= 1'b0;
    end else begin
      n <= (outs.pilot_valve && light) ? n + 1 : 0;
      flame <= outs.pilot_valve && light && n >= 20;
    end
  end
endmodule // bsq_burner_model

// ### bench/bsq_sequencer_props.sv
// Port checks of the burner sequencer
`timescale 1ns/1ps
`include "bsq_defines.svh"
module bsq_sequencer_props #(
  parameter int TENTH_CYCLES = 4,
  parameter int TENTHS_PER_HOUR = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire bsq_pkg::bsq_pins_t pins,
  input wire bsq_pkg::bsq_outs_t outs,
  input wire logic [7:0] fault_code,
  input wire logic irq,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata
);
  import bsq_pkg::*;
  logic [31:0] purge_cnt;
  logic [31:0] loss_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles of a standing start request, and of flame loss with main open
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      purge_cnt <= 32'h0;
      loss_cnt <= 32'h0;
    end else begin
      purge_cnt <= (pins.call_heat && pins.airflow_proving_switch && pins.limits_ok &&
        pins.power_ok) ? purge_cnt + {31'h0, ~&purge_cnt} : 32'h0;
      loss_cnt <= (outs.main_valve && !pins.flame) ? loss_cnt + 32'h1 : 32'h0;
    end
  end
  a_purge_time: assert property (
    $rose(outs.pilot_valve) |-> purge_cnt >= 299 * TENTH_CYCLES)
    else $error("pilot opened before purge end");
  a_loss_bound: assert property (
    loss_cnt <= 31 * TENTH_CYCLES + 8)
    else $error("main valve open too long without flame");
  a_main_flame: assert property (
    $rose(outs.main_valve) |-> pins.flame && $past(pins.flame, 4))
    else $error("main valve opened without flame");
  a_call_drop: assert property (
    (!pins.call_heat) [*8] |-> !outs.pilot_valve && !outs.main_valve)
    else $error("valves open without call");
  a_fault_hold: assert property (
    fault_code == `BSQ_FAULT_CODE |=> fault_code == `BSQ_FAULT_CODE && outs.alarm &&
      !outs.pilot_valve && !outs.main_valve)
    else $error("fault state left or unsafe");
  a_fault_cause: assert property (
    $changed(fault_code) |-> fault_code == `BSQ_FAULT_CODE && $past(fault_code) == 8'h0)
    else $error("bad fault code change");
  a_rdata_idle: assert property (
    !$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  a_irq_masked: assert property (
    wr_en && addr == `BSQ_OFS_INT_MASK && wdata[4:0] == 5'h0 |=> !irq)
    else $error("interrupt with all sources masked");
endmodule // bsq_sequencer_props

bind bsq_sequencer bsq_sequencer_props #(
  .TENTH_CYCLES(TENTH_CYCLES), .TENTHS_PER_HOUR(TENTHS_PER_HOUR)
) u_props (
  .clk_sys(clk_sys), .rst(rst), .pins(pins), .outs(outs), .fault_code(fault_code), .irq(irq),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata)
);

// ### bench/bsq_sequencer_tb_top.sv
// Self-checking bench for the burner sequencer
`timescale 1ns/1ps
`include "bsq_defines.svh"
module bsq_sequencer_tb_top;
  import bsq_pkg::*;
  localparam int TC = 4;
  localparam int PP = `BSQ_PREPURGE_S * 10 * TC;
  localparam int PS = `BSQ_PILOT_SHORT_S * 10 * TC;
  bsq_pins_t pin, pins;
  bsq_outs_t outs;
  logic clk_sys, rst, irq, wr_en, rd_en, light, flame;
  logic [7:0] fault_code, addr;
  logic [31:0] wdata, rdata, rd, ctl;
  int ev_q[$];
  int mismatches, cmp_count, n, i, t;

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Flame sensor comes from the burner model
  always_comb begin
    pins = pin;
    pins.flame = flame;
  end

  bsq_sequencer #(.TENTH_CYCLES(TC), .TENTHS_PER_HOUR(50)) uut (
    .clk_sys(clk_sys), .rst(rst), .pins(pins), .outs(outs), .fault_code(fault_code),
    .irq(irq), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
  bsq_burner_model burner (
    .clk_sys(clk_sys), .rst(rst), .outs(outs), .light(light), .flame(flame));

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic rng(input string s, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", s, lo, hi, n);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic reg_rd(input logic [7:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    rd = rdata;
    @(posedge clk_sys);
  endtask

  // Counts cycles until one output bit takes a value
  task automatic wait_out(input int b, input logic v, input int lim);
    n = 0;
    while (outs[b] !== v) begin
      @(posedge clk_sys);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("MISMATCH output %0d expected %b seen %b", b, v, outs[b]);
        end_of_test();
      end
    end
  endtask

  task automatic chk_ev();
    reg_rd(`BSQ_OFS_INT_STAT);
    chk("int stat", ev_q.pop_front(), rd);
    chk("irq", 32'h1, {31'h0, irq});
    reg_wr(`BSQ_OFS_INT_STAT, rd);
    @(negedge clk_sys);
    chk("irq clear", 32'h0, {31'h0, irq});
    @(posedge clk_sys);
  endtask

  task automatic go();
    reg_wr(`BSQ_OFS_INT_STAT, 32'h1f);
    pin.call_heat <= 1'b1;
  endtask

  task automatic stop();
    pin.call_heat <= 1'b0;
    repeat (12) @(posedge clk_sys);
    reg_wr(`BSQ_OFS_CTRL, ctl | 32'h2);
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    pin = '0;
    pin.airflow_proving_switch = 1'b1;
    pin.limits_ok = 1'b1;
    pin.power_ok = 1'b1;
    {addr, wdata, wr_en, rd_en, ctl} = '0;
    light = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    t = $urandom(32'h092a7206);
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    // Reset values, read-only and unmapped places, random mask
    reg_rd(`BSQ_OFS_CTRL);
    chk("ctrl", 32'h0, rd);
    t = $urandom;
    reg_wr(8'h20, 32'(t));
    reg_wr(`BSQ_OFS_FAULT, 32'(t));
    reg_rd(8'h20);
    chk("unmapped", 32'h0, rd);
    reg_rd(`BSQ_OFS_FAULT);
    chk("fault reg", 32'h0, rd);
    reg_wr(`BSQ_OFS_INT_MASK, 32'(t));
    reg_rd(`BSQ_OFS_INT_MASK);
    chk("int mask", {27'h0, 5'(t)}, rd);
    reg_wr(`BSQ_OFS_INT_MASK, 32'h0);
    reg_wr(`BSQ_OFS_INT_MASK, 32'h1f);
    $display("done registers");
    // Normal start with both trial lengths, run held until the call drops
    for (i = 0; i < 2; i++) begin
      pin.pilot_time_option <= i[0];
      go();
      wait_out(3, 1'b1, 1400);
      rng("purge", PP - TC, PP + 16);
      chk("igniter on", 32'h1, {31'h0, outs.igniter});
      t = i == 1 ? PS : `BSQ_PILOT_LONG_S * 10 * TC;
      wait_out(1, 1'b1, 500);
      rng("pilot trial", t - TC, t + TC + 4);
      repeat (600) @(posedge clk_sys);
      chk("run held", 32'h1, {31'h0, outs.main_valve});
      chk("igniter off", 32'h0, {31'h0, outs.igniter});
      ev_q.push_back(1 << `BSQ_EV_RUN);
      stop();
      chk_ev();
    end
    $display("done normal start");
    // Test position freezes the purge, run resumes it
    go();
    repeat (600) @(posedge clk_sys);
    pin.test_sel <= 1'b1;
    repeat (1000) @(posedge clk_sys);
    chk("frozen purge", 32'h0, {31'h0, outs.pilot_valve});
    pin.test_sel <= 1'b0;
    wait_out(3, 1'b1, 800);
    rng("resumed purge", PP - 600 - TC, PP - 600 + 12);
    stop();
    $display("done purge test");
    // Test halts the short trial; flame loss while held is tolerated for a while
    for (i = 0; i < 2; i++) begin
      go();
      wait_out(3, 1'b1, 1400);
      pin.test_sel <= 1'b1;
      repeat (500) @(posedge clk_sys);
      chk("trial halted", 32'h0, {31'h0, outs.main_valve});
      if (i == 0) begin
        reg_rd(`BSQ_OFS_STATUS);
        chk("status held", {19'h0, 3'b111, 3'h2, 4'b1100, 3'b001}, rd);
        pin.test_sel <= 1'b0;
        wait_out(1, 1'b1, 200);
        t = (`BSQ_PILOT_SHORT_S - `BSQ_HOLD_SHORT_S) * 10 * TC;
        rng("trial rest", t - TC, t + 12);
      end else begin
        light <= 1'b0;
        wait_out(3, 1'b0, 800);
        t = `BSQ_FLAMEOUT_S * 10 * TC;
        rng("flameout", t - TC, t + 12);
      end
      ev_q.push_back((1 << `BSQ_EV_HOLD) | (i == 1 ? 1 << `BSQ_EV_LOCKOUT : 0));
      stop();
      chk_ev();
      pin.test_sel <= 1'b0;
      light <= 1'b1;
    end
    // Strapped valve terminals make the trial ignore the test position
    pin.valves_strapped <= 1'b1;
    go();
    wait_out(3, 1'b1, 1400);
    pin.test_sel <= 1'b1;
    wait_out(1, 1'b1, 400);
    rng("strapped trial", PS - TC, PS + TC + 4);
    stop();
    pin.test_sel <= 1'b0;
    pin.valves_strapped <= 1'b0;
    $display("done pilot test");
    // No flame at trial end shuts down
    light <= 1'b0;
    go();
    wait_out(3, 1'b1, 1400);
    wait_out(3, 1'b0, 400);
    rng("no flame trial", PS - TC, PS + TC + 4);
    ev_q.push_back(1 << `BSQ_EV_LOCKOUT);
    stop();
    chk_ev();
    light <= 1'b1;
    $display("done no flame");
    // Flame loss in run with each response time and flame-failure action
    for (i = 0; i < 2; i++) begin
      ctl = i;
      reg_wr(`BSQ_OFS_CTRL, ctl);
      pin.flame_fail_option <= i[0];
      go();
      wait_out(1, 1'b1, 2000);
      repeat (500) @(posedge clk_sys);
      light <= 1'b0;
      t = (i == 1 ? `BSQ_FLAME_LOSS_RESPONSE_TIME_LONG_MS : `BSQ_FLAME_LOSS_RESPONSE_TIME_SHORT_MS) / 100 * TC;
      wait_out(1, 1'b0, 200);
      rng("flame loss", t - TC, t + 12);
      ev_q.push_back(8 | (1 << (i == 1 ? `BSQ_EV_LOCKOUT : `BSQ_EV_RECYCLE)));
      stop();
      chk_ev();
      light <= 1'b1;
    end
    $display("done flame");
    // Interlock loss in the trial: recycle when intact, lockout when clipped
    for (i = 0; i < 2; i++) begin
      pin.airflow_fail_option <= i[0];
      go();
      wait_out(3, 1'b1, 1400);
      pin.airflow_proving_switch <= 1'b0;
      wait_out(3, 1'b0, 20);
      chk("alarm", {31'h0, i[0]}, {31'h0, outs.alarm});
      ev_q.push_back(1 << (i == 1 ? `BSQ_EV_LOCKOUT : `BSQ_EV_RECYCLE));
      stop();
      pin.airflow_proving_switch <= 1'b1;
      chk_ev();
    end
    pin.airflow_fail_option <= 1'b0;
    $display("done airflow");
    // Clipping an option after 200 hours is a lasting fault
    n = 0;
    do begin
      repeat (200) @(posedge clk_sys);
      reg_rd(`BSQ_OFS_HOURS);
      n++;
    end while (rd < `BSQ_CLIP_HOURS && n < 300);
    chk("hours", 32'h1, {31'h0, rd >= `BSQ_CLIP_HOURS});
    go();
    repeat (100) @(posedge clk_sys);
    pin.airflow_fail_option <= 1'b1;
    wait_out(0, 1'b1, 20);
    chk("fault code", `BSQ_FAULT_CODE, fault_code);
    ev_q.push_back(1 << `BSQ_EV_FAULT);
    stop();
    chk_ev();
    repeat (20) @(posedge clk_sys);
    chk("fault kept", `BSQ_FAULT_CODE, fault_code);
    $display("done fault");
    end_of_test();
  end
endmodule // bsq_sequencer_tb_top

// ### hdl/bsq_sequencer.sv
// Burner sequencer with run/test selector, site options and register port
// Summary of operation
// RQ1 - Test freezes pre-purge timer, no advance
// RQ2 - Test halts pilot timer at 8/3 seconds
// RQ3 - Test starts 15-second flameout tolerance timer
// RQ4 - Strapped valves: ignore test during pilot trial
// RQ5 - Test runs to next hold point, waits
// RQ6 - Pilot option sets 10 or 4 seconds
// RQ7 - Options select recycle or lockout on failures
// RQ8 - Late option clip gives permanent fault 100
// RQ9 - Call for heat times 30-second pre-purge
// RQ10 - No flame at trial end: safety shutdown
// RQ11 - Flame loss: act within 0.8/3 seconds
// RQ12 - Stay in run until call drops
// RQ13 - Frozen timers resume; tenth-second tick drives periods
`timescale 1ns/1ps
`include "bsq_defines.svh"

module bsq_sequencer #(
  parameter int TENTH_CYCLES = `BSQ_TENTH_CYCLES,
  parameter int TENTHS_PER_HOUR = `BSQ_TENTHS_PER_HOUR
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire bsq_pkg::bsq_pins_t pins,
  output bsq_pkg::bsq_outs_t outs,
  output logic [7:0] fault_code,
  output logic irq,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata
);
  import bsq_pkg::*;

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  bsq_st_t q;
  bsq_st_t next_q;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic tick;
    logic [9:0] agree;
    logic [4:0] ev;
    logic [4:0] w1c;
    logic cond_ok;
    logic test_eff;
    logic [9:0] period;
    logic [9:0] hold_pt;
    logic [5:0] flame_loss_response_time_lim;
    logic flame_lost_act;
    logic air_lost_act;
    logic lock_clr;
    tick = 1'b0;
    agree = 10'h000;
    ev = 5'h00;
    w1c = 5'h00;
    cond_ok = 1'b0;
    test_eff = 1'b0;
    period = 10'h000;
    hold_pt = 10'h000;
    flame_loss_response_time_lim = 6'h00;
    flame_lost_act = 1'b0;
    air_lost_act = 1'b0;
    lock_clr = 1'b0;
    next_q = q;
    next_q.rdata = 32'h0000_0000;

    // Pin synchroniser; filtered value moves when stages two and three agree
    next_q.s1 = pins;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    next_q.filt = (q.s3 & agree) | (q.filt & ~agree);
    if (q.settle != 2'h3) begin
      next_q.settle = q.settle + 2'h1;
    end

    // Tenth-second timebase derived from the system clock
    if (q.pre == 22'(TENTH_CYCLES - 1)) begin
      next_q.pre = 22'h0;
      tick = 1'b1; // see RQ13
    end else begin
      next_q.pre = q.pre + 22'h1;
    end

    // Operating hours since power-up
    if (tick) begin
      if (q.tenths == 16'(TENTHS_PER_HOUR - 1)) begin
        next_q.tenths = 16'h0;
        if (q.hours != 16'hffff) begin
          next_q.hours = q.hours + 16'h1;
        end
      end else begin
        next_q.tenths = q.tenths + 16'h1;
      end
    end

    // Register writes
    if (wr_en) begin
      case (addr)
        `BSQ_OFS_CTRL: begin
          next_q.flame_loss_response_time_long = wdata[`BSQ_CTRL_FLAME_LOSS_RESPONSE_TIME_LONG];
          lock_clr = wdata[`BSQ_CTRL_LOCK_CLR];
        end
        `BSQ_OFS_INT_STAT: begin
          w1c = wdata[4:0];
        end
        `BSQ_OFS_INT_MASK: begin
          next_q.int_mask = wdata[4:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads, data in the following cycle only
    if (rd_en) begin
      case (addr)
        `BSQ_OFS_CTRL: next_q.rdata = {31'h0, q.flame_loss_response_time_long};
        `BSQ_OFS_STATUS: next_q.rdata = {16'h0, 3'h0, q.held, q.filt.test_sel,
                                         q.filt.flame, 3'(q.state), q.outs, q.opt_ref};
        `BSQ_OFS_INT_STAT: next_q.rdata = {27'h0, q.int_stat};
        `BSQ_OFS_INT_MASK: next_q.rdata = {27'h0, q.int_mask};
        `BSQ_OFS_HOURS: next_q.rdata = {16'h0, q.hours};
        `BSQ_OFS_FAULT: next_q.rdata = {24'h0, q.fault_code};
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end

    // Shared sequence terms
    cond_ok = q.filt.call_heat & q.filt.airflow_proving_switch & q.filt.limits_ok
              & q.filt.power_ok;
    test_eff = q.filt.test_sel & ~q.filt.valves_strapped; // see RQ4
    period = q.filt.pilot_time_option ? `BSQ_S2T(`BSQ_PILOT_SHORT_S)
                                      : `BSQ_S2T(`BSQ_PILOT_LONG_S); // see RQ6
    hold_pt = q.filt.pilot_time_option ? `BSQ_S2T(`BSQ_HOLD_SHORT_S)
                                       : `BSQ_S2T(`BSQ_HOLD_LONG_S); // see RQ2
    flame_loss_response_time_lim = q.flame_loss_response_time_long ? `BSQ_MS2T(`BSQ_FLAME_LOSS_RESPONSE_TIME_LONG_MS)
                           : `BSQ_MS2T(`BSQ_FLAME_LOSS_RESPONSE_TIME_SHORT_MS);
    flame_lost_act = q.filt.flame_fail_option;
    air_lost_act = q.filt.airflow_fail_option;

    // Sequence steps
    case (q.state)
      ST_STANDBY: begin
        next_q.timer = 10'h0;
        next_q.held = 1'b0;
        if (cond_ok && q.settle == 2'h3) begin
          next_q.state = ST_PREPURGE; // see RQ9
        end
      end
      ST_PREPURGE: begin
        next_q.held = q.filt.test_sel;
        if (!q.filt.call_heat) begin
          next_q.state = ST_STANDBY;
        end else if (!cond_ok) begin
          next_q.state = air_lost_act ? ST_LOCKOUT : ST_STANDBY; // see RQ7
          ev[air_lost_act ? `BSQ_EV_LOCKOUT : `BSQ_EV_RECYCLE] = 1'b1;
        end else if (q.timer >= `BSQ_S2T(`BSQ_PREPURGE_S)) begin
          if (!q.filt.test_sel) begin
            next_q.state = ST_PILOT; // see RQ1
            next_q.timer = 10'h0;
            next_q.fo_timer = 8'h0;
          end
        end else if (tick && !q.filt.test_sel) begin
          next_q.timer = q.timer + 10'h1; // see RQ1, RQ13
        end
        if (q.filt.test_sel && !q.held) begin
          ev[`BSQ_EV_HOLD] = 1'b1;
        end
      end
      ST_PILOT: begin
        next_q.held = test_eff && q.timer >= hold_pt; // see RQ5
        if (!q.filt.call_heat) begin
          next_q.state = ST_STANDBY;
        end else if (!cond_ok) begin
          next_q.state = air_lost_act ? ST_LOCKOUT : ST_STANDBY; // see RQ7
          ev[air_lost_act ? `BSQ_EV_LOCKOUT : `BSQ_EV_RECYCLE] = 1'b1;
        end else if (test_eff && q.timer >= hold_pt) begin
          // Timer halted; flame loss tolerated for a while
          if (!q.held) begin
            ev[`BSQ_EV_HOLD] = 1'b1;
          end
          if (q.filt.flame) begin
            next_q.fo_timer = 8'h0;
          end else if (q.fo_timer >= 8'(`BSQ_S2T(`BSQ_FLAMEOUT_S))) begin
            next_q.state = ST_LOCKOUT; // see RQ3
            ev[`BSQ_EV_LOCKOUT] = 1'b1;
          end else if (tick) begin
            next_q.fo_timer = q.fo_timer + 8'h1; // see RQ3
          end
        end else if (q.timer >= period) begin
          next_q.timer = 10'h0;
          next_q.flame_loss_response_time_timer = 6'h0;
          if (q.filt.flame) begin
            next_q.state = ST_MAIN;
          end else begin
            next_q.state = ST_LOCKOUT; // see RQ10
            ev[`BSQ_EV_LOCKOUT] = 1'b1;
          end
        end else if (tick) begin
          next_q.timer = q.timer + 10'h1; // see RQ2, RQ13
          next_q.fo_timer = 8'h0;
        end
      end
      ST_MAIN, ST_RUN: begin
        next_q.held = 1'b0;
        if (!q.filt.call_heat) begin
          next_q.state = ST_STANDBY; // see RQ12
        end else if (!cond_ok) begin
          next_q.state = air_lost_act ? ST_LOCKOUT : ST_STANDBY; // see RQ7
          ev[air_lost_act ? `BSQ_EV_LOCKOUT : `BSQ_EV_RECYCLE] = 1'b1;
        end else if (!q.filt.flame && q.flame_loss_response_time_timer >= flame_loss_response_time_lim) begin
          next_q.state = flame_lost_act ? ST_LOCKOUT : ST_STANDBY; // see RQ11
          ev[flame_lost_act ? `BSQ_EV_LOCKOUT : `BSQ_EV_RECYCLE] = 1'b1;
        end else begin
          if (q.filt.flame) begin
            next_q.flame_loss_response_time_timer = 6'h0;
          end else if (tick) begin
            next_q.flame_loss_response_time_timer = q.flame_loss_response_time_timer + 6'h1; // see RQ11
          end
          if (q.state == ST_MAIN) begin
            if (q.timer >= `BSQ_S2T(`BSQ_MAIN_S)) begin
              next_q.state = ST_RUN;
              ev[`BSQ_EV_RUN] = 1'b1;
            end else if (tick) begin
              next_q.timer = q.timer + 10'h1;
            end
          end
        end
      end
      ST_LOCKOUT: begin
        next_q.held = 1'b0;
        if (lock_clr) begin
          next_q.state = ST_STANDBY;
        end
      end
      ST_FAULT: begin
        next_q.state = ST_FAULT; // see RQ8
      end
      default: begin
        next_q.state = ST_LOCKOUT;
      end
    endcase

    // Option watch: clips accepted early, fatal after the hour limit
    if (q.settle == 2'h2) begin
      next_q.opt_ref = {q.filt.airflow_fail_option, q.filt.flame_fail_option,
                        q.filt.pilot_time_option};
    end else if (q.settle == 2'h3) begin
      if (q.hours >= 16'(`BSQ_CLIP_HOURS) && q.state != ST_FAULT &&
          (|(~q.opt_ref & {q.filt.airflow_fail_option, q.filt.flame_fail_option,
                           q.filt.pilot_time_option}))) begin
        next_q.state = ST_FAULT; // see RQ8
        next_q.fault_code = `BSQ_FAULT_CODE;
        ev[`BSQ_EV_FAULT] = 1'b1;
      end else if (q.hours < 16'(`BSQ_CLIP_HOURS)) begin
        next_q.opt_ref = {q.filt.airflow_fail_option, q.filt.flame_fail_option,
                          q.filt.pilot_time_option};
      end
    end

    // Sticky events; a new event beats a same-cycle clear
    next_q.int_stat = (q.int_stat & ~w1c) | ev;

    // Burner outputs decoded from the next step
    next_q.outs = '0;
    case (next_q.state)
      ST_PILOT: begin
        next_q.outs.pilot_valve = 1'b1;
        next_q.outs.igniter = 1'b1;
      end
      ST_MAIN, ST_RUN: begin
        next_q.outs.pilot_valve = 1'b1;
        next_q.outs.main_valve = 1'b1;
      end
      ST_LOCKOUT, ST_FAULT: begin
        next_q.outs.alarm = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State flip-flops
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.state <= ST_STANDBY;
      q.flame_loss_response_time_long <= `BSQ_CTRL_RST;
      q.int_mask <= `BSQ_MASK_RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign outs = q.outs;
  assign fault_code = q.fault_code;
  assign rdata = q.rdata;
  assign irq = |(q.int_stat & q.int_mask); // Level, high while unmasked event

endmodule // bsq_sequencer

// ### shared/bsq_defines.svh
// Offsets, field positions, reset values and timing counts of the burner sequencer
`ifndef BSQ_DEFINES_SVH
`define BSQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BSQ_OFS_CTRL 8'h00
`define BSQ_OFS_STATUS 8'h04
`define BSQ_OFS_INT_STAT 8'h08
`define BSQ_OFS_INT_MASK 8'h0c
`define BSQ_OFS_HOURS 8'h10
`define BSQ_OFS_FAULT 8'h14

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BSQ_CTRL_FLAME_LOSS_RESPONSE_TIME_LONG 0
`define BSQ_CTRL_LOCK_CLR 1
`define BSQ_CTRL_RST 1'b0
`define BSQ_MASK_RST 5'h00
`define BSQ_EV_LOCKOUT 0
`define BSQ_EV_FAULT 1
`define BSQ_EV_RECYCLE 2
`define BSQ_EV_RUN 3
`define BSQ_EV_HOLD 4
`define BSQ_FAULT_CODE 8'h64

// ----------------------------------------------------------------------
// Timing: clock, base tick and sequence periods
// ----------------------------------------------------------------------
`define BSQ_CLK_NS 40
`define BSQ_TENTH_NS 100000000
`define BSQ_TENTH_CYCLES (`BSQ_TENTH_NS / `BSQ_CLK_NS)
`define BSQ_HOUR_S 3600
`define BSQ_TENTHS_PER_HOUR (`BSQ_HOUR_S * 10)
`define BSQ_PREPURGE_S 30
`define BSQ_PILOT_LONG_S 10
`define BSQ_PILOT_SHORT_S 4
`define BSQ_HOLD_LONG_S 8
`define BSQ_HOLD_SHORT_S 3
`define BSQ_FLAMEOUT_S 15
`define BSQ_MAIN_S 10
`define BSQ_FLAME_LOSS_RESPONSE_TIME_SHORT_MS 800
`define BSQ_FLAME_LOSS_RESPONSE_TIME_LONG_MS 3000
`define BSQ_CLIP_HOURS 200
`define BSQ_S2T(s) (10'((s) * 10))
`define BSQ_MS2T(ms) (6'((ms) / 100))

`endif

// ### shared/bsq_pkg.sv
// Types shared by the burner sequencer design
package bsq_pkg;

  // Sequence steps
  typedef enum logic [2:0] {
    ST_STANDBY, ST_PREPURGE, ST_PILOT, ST_MAIN, ST_RUN, ST_LOCKOUT, ST_FAULT
  } bsq_state_t;

  // Burner-side inputs, all asynchronous to clk_sys
  typedef struct packed {
    logic call_heat;
    logic airflow_proving_switch;
    logic limits_ok;
    logic power_ok;
    logic flame;
    logic test_sel;
    logic valves_strapped;
    logic airflow_fail_option;
    logic flame_fail_option;
    logic pilot_time_option;
  } bsq_pins_t;

  // Burner-side outputs
  typedef struct packed {
    logic pilot_valve;
    logic igniter;
    logic main_valve;
    logic alarm;
  } bsq_outs_t;

  // Whole state of the sequencer
  typedef struct packed {
    bsq_pins_t s1;
    bsq_pins_t s2;
    bsq_pins_t s3;
    bsq_pins_t filt;
    logic [1:0] settle;
    logic [2:0] opt_ref;
    logic [21:0] pre;
    logic [15:0] tenths;
    logic [15:0] hours;
    bsq_state_t state;
    logic [9:0] timer;
    logic [7:0] fo_timer;
    logic [5:0] flame_loss_response_time_timer;
    logic held;
    logic flame_loss_response_time_long;
    logic [4:0] int_stat;
    logic [4:0] int_mask;
    logic [31:0] rdata;
    bsq_outs_t outs;
    logic [7:0] fault_code;
  } bsq_st_t;

endpackage
